// *** verilog/sbm_pkg.sv ***
// constants, register map and state types for the two-wire serial bus master
package sbm_pkg;

  // clocking
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SCL_NORM_HZ = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;
  // one quarter of a serial clock period, in pclk cycles (rounded down)
  localparam logic [9:0] QTR_NORM = 10'(CLK_HZ / (4 * SCL_NORM_HZ));
  localparam logic [9:0] QTR_FAST = 10'(CLK_HZ / (4 * SCL_FAST_HZ));
  // settle time before the clock line is sensed for a pull-up (rounded up)
  localparam int unsigned SETTLE_NS = 1000;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

  // register indices and byte addresses (index times four)
  localparam logic [7:0] IDX_DATA = 8'hb0;
  localparam logic [7:0] IDX_INDEX = 8'hb1;
  localparam logic [7:0] IDX_TARGET = 8'hb2;
  localparam logic [7:0] IDX_CTRL = 8'hb3;
  localparam logic [7:0] IDX_INT_STAT = 8'hb4;
  localparam logic [7:0] IDX_INT_EN = 8'hb5;
  localparam logic [7:0] IDX_INT_CLR = 8'hb6;
  localparam logic [11:0] ADDR_DATA = 12'({IDX_DATA, 2'b00});
  localparam logic [11:0] ADDR_INDEX = 12'({IDX_INDEX, 2'b00});
  localparam logic [11:0] ADDR_TARGET = 12'({IDX_TARGET, 2'b00});
  localparam logic [11:0] ADDR_CTRL = 12'({IDX_CTRL, 2'b00});
  localparam logic [11:0] ADDR_INT_STAT = 12'({IDX_INT_STAT, 2'b00});
  localparam logic [11:0] ADDR_INT_EN = 12'({IDX_INT_EN, 2'b00});
  localparam logic [11:0] ADDR_INT_CLR = 12'({IDX_INT_CLR, 2'b00});

  // control/status field positions
  localparam int unsigned B_SHORT = 7;
  localparam int unsigned B_RSVD = 6;
  localparam int unsigned B_REQ_BUSY = 5;
  localparam int unsigned B_AUTO_BUSY = 4;
  localparam int unsigned B_PRESENT = 3;
  localparam int unsigned B_FAST = 2;
  localparam int unsigned B_REQ_ERR = 1;
  localparam int unsigned B_ROM_ERR = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // interrupt status bits
  localparam int unsigned I_REQ_DONE = 0;
  localparam int unsigned I_REQ_ERR = 1;
  localparam int unsigned I_AUTO_DONE = 2;
  localparam int unsigned I_AUTO_ERR = 3;

  // autoload: rom device address, format marker and last byte index
  localparam logic [6:0] ROM_DEV_ADDR = 7'h50;
  localparam logic [7:0] ROM_FORMAT = 8'ha5;
  localparam logic [1:0] AUTO_LAST = 2'h2;

  typedef enum logic [1:0] {st_idle, st_start, st_bit, st_stop} sbm_state_t;
  typedef enum logic [2:0] {sp_addr, sp_index, sp_wdata, sp_raddr, sp_rdata} sbm_step_t;

endpackage

// *** verilog/sbm_sync.sv ***
// two-flop synchronisers for the serial bus line levels
`timescale 1ns/10ps
module sbm_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels from the pins and their synchronised copies
  input wire logic [W-1:0] async_lvl,
  output logic [W-1:0] sync_ff
);

  logic [W-1:0] meta_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= async_lvl[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

endmodule

// *** verilog/sbm_serial_ctrl.sv ***
// serial bus master: apb registers, requested byte transfers and rom autoload
//
// Function
// - short protocol skips index byte entirely
// - target address write starts request, sets busy
// - autoload busy reads one during rom load
// - sense clock pull-up after reset, set present
// - fast test bit raises serial clock rate
// - missing acknowledge on request sets error
// - request error cleared by writing one
// - missing acknowledge during autoload sets rom error
// - bad rom format marker sets rom error
// - rom error cleared by writing one
// - status bit six reads zero always
// - address bit zero selects write or read
// - bits seven to one give target address
// - index sent, data written or loaded
`timescale 1ns/10ps
module sbm_serial_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // two-wire bus, open drain
  input wire logic scl_sense,
  output logic scl_val_ff,
  output logic scl_oe_ff,
  input wire logic sda_sense,
  output logic sda_val_ff,
  output logic sda_oe_ff,
  // system
  output logic irq_ff,
  output logic [15:0] subsys_id_ff
);

  logic scl_s;
  logic sda_s;
  logic acc;
  logic wr_en;
  logic [7:0] ctrl_rd;
  logic [31:0] nxt_prdata;
  logic [7:0] target_ff;
  logic [7:0] index_ff;
  logic [7:0] data_ff;
  logic short_sel_ff;
  logic fast_clk_ff;
  logic bus_present_ff;
  logic req_err_ff;
  logic rom_err_ff;
  logic [3:0] int_stat_ff;
  logic [3:0] int_en_ff;
  logic [7:0] boot_cnt_ff;
  logic boot_done_ff;
  logic boot_pulse_ff;
  logic [9:0] div_ff;
  logic tick_ff;
  sbm_pkg::sbm_state_t st_ff;
  sbm_pkg::sbm_step_t step_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [8:0] tx_ff;
  logic [7:0] rx_ff;
  logic ack_ff;
  logic op_err_ff;
  logic op_read_ff;
  logic op_short_ff;
  logic op_auto_ff;
  logic req_busy_ff;
  logic auto_busy_ff;
  logic [1:0] auto_cnt_ff;
  logic ev_req_done_ff;
  logic ev_req_err_ff;
  logic ev_auto_done_ff;
  logic ev_auto_err_ff;
  logic ev_rx_load_ff;

  sbm_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_lvl({scl_sense, sda_sense}),
    .sync_ff({scl_s, sda_s})
  );

  // apb: one wait state, so read data comes from a register
  assign acc = psel & penable;
  assign wr_en = acc & pready_ff & pwrite;

  assign ctrl_rd = {short_sel_ff, 1'b0, req_busy_ff, auto_busy_ff,
                    bus_present_ff, fast_clk_ff, req_err_ff, rom_err_ff};

  always_comb begin
    nxt_prdata = 32'h0;
    case (paddr)
      sbm_pkg::ADDR_DATA: nxt_prdata = {24'h0, data_ff};
      sbm_pkg::ADDR_INDEX: nxt_prdata = {24'h0, index_ff};
      sbm_pkg::ADDR_TARGET: nxt_prdata = {24'h0, target_ff};
      sbm_pkg::ADDR_CTRL: nxt_prdata = {24'h0, ctrl_rd};
      sbm_pkg::ADDR_INT_STAT: nxt_prdata = {28'h0, int_stat_ff};
      sbm_pkg::ADDR_INT_EN: nxt_prdata = {28'h0, int_en_ff};
      default: nxt_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc & ~pready_ff;
      pslverr_ff <= 1'b0;
      if (acc && !pready_ff && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // transfer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_ff <= 8'h00;
      index_ff <= 8'h00;
      data_ff <= 8'h00;
    end else begin
      if (wr_en && paddr == sbm_pkg::ADDR_TARGET) begin
        target_ff <= pwdata[7:0];
      end
      if (wr_en && paddr == sbm_pkg::ADDR_INDEX) begin
        index_ff <= pwdata[7:0];
      end
      if (ev_rx_load_ff) begin
        data_ff <= rx_ff;
      end else if (wr_en && paddr == sbm_pkg::ADDR_DATA) begin
        data_ff <= pwdata[7:0];
      end
    end
  end

  // control and status; a hardware set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_sel_ff <= sbm_pkg::CTRL_RESET[sbm_pkg::B_SHORT];
      fast_clk_ff <= sbm_pkg::CTRL_RESET[sbm_pkg::B_FAST];
      bus_present_ff <= sbm_pkg::CTRL_RESET[sbm_pkg::B_PRESENT];
      req_err_ff <= sbm_pkg::CTRL_RESET[sbm_pkg::B_REQ_ERR];
      rom_err_ff <= sbm_pkg::CTRL_RESET[sbm_pkg::B_ROM_ERR];
    end else begin
      if (wr_en && paddr == sbm_pkg::ADDR_CTRL) begin
        short_sel_ff <= pwdata[sbm_pkg::B_SHORT];
        fast_clk_ff <= pwdata[sbm_pkg::B_FAST];
        bus_present_ff <= pwdata[sbm_pkg::B_PRESENT];
      end
      if (boot_pulse_ff) begin
        bus_present_ff <= scl_s;
      end
      if (ev_req_err_ff) begin
        req_err_ff <= 1'b1;
      end else if (wr_en && paddr == sbm_pkg::ADDR_CTRL && pwdata[sbm_pkg::B_REQ_ERR]) begin
        req_err_ff <= 1'b0;
      end
      if (ev_auto_err_ff) begin
        rom_err_ff <= 1'b1;
      end else if (wr_en && paddr == sbm_pkg::ADDR_CTRL && pwdata[sbm_pkg::B_ROM_ERR]) begin
        rom_err_ff <= 1'b0;
      end
    end
  end

  // interrupts: sticky status, write-one clear, enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_ff <= 4'h0;
      int_en_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_en && paddr == sbm_pkg::ADDR_INT_EN) begin
        int_en_ff <= pwdata[3:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_en && paddr == sbm_pkg::ADDR_INT_CLR && pwdata[i]) begin
          int_stat_ff[i] <= 1'b0;
        end
      end
      if (ev_req_done_ff) begin
        int_stat_ff[sbm_pkg::I_REQ_DONE] <= 1'b1;
      end
      if (ev_req_err_ff) begin
        int_stat_ff[sbm_pkg::I_REQ_ERR] <= 1'b1;
      end
      if (ev_auto_done_ff) begin
        int_stat_ff[sbm_pkg::I_AUTO_DONE] <= 1'b1;
      end
      if (ev_auto_err_ff) begin
        int_stat_ff[sbm_pkg::I_AUTO_ERR] <= 1'b1;
      end
      irq_ff <= |(int_stat_ff & int_en_ff);
    end
  end

  // wait for the lines to settle after reset before sensing the pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_ff <= 8'h00;
      boot_done_ff <= 1'b0;
      boot_pulse_ff <= 1'b0;
    end else begin
      boot_pulse_ff <= 1'b0;
      if (!boot_done_ff) begin
        boot_cnt_ff <= boot_cnt_ff + 8'h01;
        if (boot_cnt_ff == sbm_pkg::SETTLE_CYC) begin
          boot_done_ff <= 1'b1;
          boot_pulse_ff <= 1'b1;
        end
      end
    end
  end

  // quarter-bit enable; the rate switch applies at the next reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 10'h000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (div_ff == 10'h000) begin
        div_ff <= fast_clk_ff ? sbm_pkg::QTR_FAST - 10'h001 : sbm_pkg::QTR_NORM - 10'h001;
        tick_ff <= 1'b1;
      end else begin
        div_ff <= div_ff - 10'h001;
      end
    end
  end

  // byte to shift out for a step, with the acknowledge slot released
  function automatic logic [8:0] tx_for(input sbm_pkg::sbm_step_t sp);
    logic [6:0] dev;
    logic [8:0] r;
    dev = op_auto_ff ? sbm_pkg::ROM_DEV_ADDR : target_ff[7:1];
    case (sp)
      sbm_pkg::sp_addr: r = {dev, 1'b0, 1'b1};
      sbm_pkg::sp_raddr: r = {dev, 1'b1, 1'b1};
      sbm_pkg::sp_index: r = {op_auto_ff ? {6'h00, auto_cnt_ff} : index_ff, 1'b1};
      sbm_pkg::sp_wdata: r = {data_ff, 1'b1};
      default: r = 9'h1ff;
    endcase
    return r;
  endfunction

  // scl and sda are only ever pulled low; the enables carry the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_val_ff <= 1'b0;
      sda_val_ff <= 1'b0;
    end else begin
      scl_val_ff <= 1'b0;
      sda_val_ff <= 1'b0;
    end
  end

  // serial sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= sbm_pkg::st_idle;
      step_ff <= sbm_pkg::sp_addr;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      tx_ff <= 9'h1ff;
      rx_ff <= 8'h00;
      ack_ff <= 1'b0;
      op_err_ff <= 1'b0;
      op_read_ff <= 1'b0;
      op_short_ff <= 1'b0;
      op_auto_ff <= 1'b0;
      req_busy_ff <= 1'b0;
      auto_busy_ff <= 1'b0;
      auto_cnt_ff <= 2'h0;
      subsys_id_ff <= 16'h0000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ev_req_done_ff <= 1'b0;
      ev_req_err_ff <= 1'b0;
      ev_auto_done_ff <= 1'b0;
      ev_auto_err_ff <= 1'b0;
      ev_rx_load_ff <= 1'b0;
    end else begin
      ev_req_done_ff <= 1'b0;
      ev_req_err_ff <= 1'b0;
      ev_auto_done_ff <= 1'b0;
      ev_auto_err_ff <= 1'b0;
      ev_rx_load_ff <= 1'b0;
      // busy drops with the data and error updates; a same-cycle target write wins
      if (wr_en && paddr == sbm_pkg::ADDR_TARGET) begin
        req_busy_ff <= 1'b1;
      end else if (ev_req_done_ff) begin
        req_busy_ff <= 1'b0;
      end
      if (boot_pulse_ff && scl_s) begin
        auto_busy_ff <= 1'b1;
      end
      case (st_ff)
        sbm_pkg::st_idle: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
          q_ff <= 2'h0;
          op_err_ff <= 1'b0;
          if (auto_busy_ff) begin
            // autoload goes first; a host request waits behind it
            op_auto_ff <= 1'b1;
            op_read_ff <= 1'b1;
            op_short_ff <= 1'b0;
            step_ff <= sbm_pkg::sp_addr;
            st_ff <= sbm_pkg::st_start;
          end else if (req_busy_ff && !ev_req_done_ff) begin
            op_auto_ff <= 1'b0;
            op_read_ff <= target_ff[0];
            op_short_ff <= short_sel_ff;
            step_ff <= (short_sel_ff && target_ff[0]) ? sbm_pkg::sp_raddr : sbm_pkg::sp_addr;
            st_ff <= sbm_pkg::st_start;
          end
        end
        sbm_pkg::st_start: begin
          if (tick_ff) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: begin
                scl_oe_ff <= 1'b1;
                sda_oe_ff <= 1'b0;
              end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin
                scl_oe_ff <= 1'b1;
                bit_ff <= 4'h0;
                tx_ff <= tx_for(step_ff);
                st_ff <= sbm_pkg::st_bit;
              end
            endcase
          end
        end
        sbm_pkg::st_bit: begin
          if (tick_ff) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: sda_oe_ff <= ~tx_ff[8];
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: begin
                if (bit_ff == 4'h8) begin
                  ack_ff <= sda_s;
                end else begin
                  rx_ff <= {rx_ff[6:0], sda_s};
                end
              end
              default: begin
                scl_oe_ff <= 1'b1;
                tx_ff <= {tx_ff[7:0], 1'b1};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h8) begin
                  bit_ff <= 4'h0;
                  if (step_ff != sbm_pkg::sp_rdata && ack_ff) begin
                    op_err_ff <= 1'b1;
                    st_ff <= sbm_pkg::st_stop;
                  end else begin
                    case (step_ff)
                      sbm_pkg::sp_addr: begin
                        step_ff <= op_short_ff ? sbm_pkg::sp_wdata : sbm_pkg::sp_index;
                        tx_ff <= tx_for(op_short_ff ? sbm_pkg::sp_wdata : sbm_pkg::sp_index);
                      end
                      sbm_pkg::sp_index: begin
                        if (op_read_ff) begin
                          step_ff <= sbm_pkg::sp_raddr;
                          st_ff <= sbm_pkg::st_start;
                        end else begin
                          step_ff <= sbm_pkg::sp_wdata;
                          tx_ff <= tx_for(sbm_pkg::sp_wdata);
                        end
                      end
                      sbm_pkg::sp_raddr: begin
                        step_ff <= sbm_pkg::sp_rdata;
                        tx_ff <= tx_for(sbm_pkg::sp_rdata);
                      end
                      default: st_ff <= sbm_pkg::st_stop;
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (tick_ff) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: sda_oe_ff <= 1'b1;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin
                st_ff <= sbm_pkg::st_idle;
                if (op_auto_ff) begin
                  auto_cnt_ff <= auto_cnt_ff + 2'h1;
                  if (!op_err_ff && auto_cnt_ff == 2'h1) begin
                    subsys_id_ff[15:8] <= rx_ff;
                  end
                  if (!op_err_ff && auto_cnt_ff == sbm_pkg::AUTO_LAST) begin
                    subsys_id_ff[7:0] <= rx_ff;
                  end
                  if (op_err_ff || (auto_cnt_ff == 2'h0 && rx_ff != sbm_pkg::ROM_FORMAT)) begin
                    ev_auto_err_ff <= 1'b1;
                  end
                  if (op_err_ff || auto_cnt_ff == sbm_pkg::AUTO_LAST ||
                      (auto_cnt_ff == 2'h0 && rx_ff != sbm_pkg::ROM_FORMAT)) begin
                    auto_busy_ff <= 1'b0;
                    auto_cnt_ff <= 2'h0;
                    ev_auto_done_ff <= 1'b1;
                  end
                end else begin
                  ev_req_done_ff <= 1'b1;
                  ev_req_err_ff <= op_err_ff;
                  ev_rx_load_ff <= op_read_ff & ~op_err_ff;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule

// *** bench/sbm_rom_model.sv ***
// two-wire target model: logs frames, acks or refuses, returns one read byte
`timescale 1ns/10ps
module sbm_rom_model (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // behaviour chosen by the bench
  input wire logic nack_all,
  input wire logic [7:0] rd_byte
);
  // 256 marks a start, 257 a stop, anything else is a received byte
  int ev_q[$];
  int cnt;
  logic [7:0] sh;
  logic first;
  logic rd;
  logic send;
  initial begin
    sda_oe = 1'b0;
    cnt = 0;
    first = 1'b0;
    rd = 1'b0;
    send = 1'b0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    ev_q.push_back(256);
    cnt = 0;
    first = 1'b1;
    send = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) ev_q.push_back(257);
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // sda only moves while scl is low, so no false start or stop is made
  always @(negedge scl) begin
    if (cnt == 8 && !send) begin
      ev_q.push_back(int'(sh));
      if (first) rd = sh[0];
      sda_oe = !nack_all;
    end else if (cnt == 9) begin
      send = first && rd && !nack_all;
      first = 1'b0;
      cnt = 0;
      sda_oe = send && !rd_byte[7];
    end else if (send && cnt < 8) sda_oe = !rd_byte[7-cnt];
    else sda_oe = 1'b0;
  end
endmodule

// *** bench/sbm_serial_ctrl_checker.sv ***
// port assertions for the serial bus master
`timescale 1ns/10ps
module sbm_serial_ctrl_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  // two-wire bus and interrupt
  input wire logic scl_val_ff,
  input wire logic scl_oe_ff,
  input wire logic sda_val_ff,
  input wire logic sda_oe_ff,
  input wire logic irq_ff
);
  localparam int QN = int'(sbm_pkg::QTR_NORM);
  localparam int QF = int'(sbm_pkg::QTR_FAST);
  logic take;
  logic irq_wr;
  logic [15:0] lo_cnt_ff;
  logic [7:0] since_tgt_ff;
  assign take = psel && penable && pready_ff;
  assign irq_wr = take && pwrite && paddr >= sbm_pkg::ADDR_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // scl low time tells the two serial rates apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt_ff <= 16'h0000;
    else lo_cnt_ff <= scl_oe_ff ? lo_cnt_ff + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_tgt_ff <= 8'hff;
    else if (take && pwrite && paddr == sbm_pkg::ADDR_TARGET) since_tgt_ff <= 8'h00;
    else if (since_tgt_ff != 8'hff) since_tgt_ff <= since_tgt_ff + 8'h01;
  end
  a_pready_wait: assert property ((psel && !penable) ##1 (psel && penable)
    |-> !pready_ff ##1 pready_ff) else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("pready longer than one cycle");
  a_no_slverr: assert property (pready_ff |-> !pslverr_ff) else $error("slave error seen");
  a_od_value_low: assert property ((scl_oe_ff || sda_oe_ff) |-> !scl_val_ff && !sda_val_ff)
    else $error("open drain value not low");
  a_rsvd_bit_zero: assert property (take && !pwrite && paddr == sbm_pkg::ADDR_CTRL
    |-> !prdata_ff[sbm_pkg::B_RSVD]) else $error("reserved bit reads one");
  a_req_sets_busy: assert property (take && !pwrite && paddr == sbm_pkg::ADDR_CTRL
    && since_tgt_ff < 8'd40 |-> prdata_ff[sbm_pkg::B_REQ_BUSY]) else $error("busy not set");
  a_req_starts_frame: assert property (take && pwrite
    && paddr == sbm_pkg::ADDR_TARGET |-> ##[1:1000] scl_oe_ff) else $error("no frame start");
  a_scl_low_time: assert property ($fell(scl_oe_ff) |-> lo_cnt_ff inside
    {[QF-2:QF+2], [2*QF-2:2*QF+2], [QN-2:QN+2], [2*QN-2:2*QN+2]})
    else $error("scl low time off rate");
  a_irq_fall_cause: assert property ($fell(irq_ff) |-> $past(irq_wr) || $past(irq_wr, 2))
    else $error("irq fell without register write");
  c_target_write: cover property (take && pwrite && paddr == sbm_pkg::ADDR_TARGET);
  c_irq_rise: cover property ($rose(irq_ff));
  c_normal_rate: cover property ($fell(scl_oe_ff) && lo_cnt_ff > 16'd1000);
endmodule

// *** bench/sbm_serial_ctrl_tb_top.sv ***
// self-checking bench for the serial bus master
`timescale 1ns/10ps
module sbm_serial_ctrl_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic irq_ff;
  logic [15:0] subsys_id_ff;
  logic rom_oe;
  logic pu_en;
  logic nack_all;
  logic [7:0] rd_byte;
  logic [15:0] rnd;
  logic [31:0] x;
  logic [31:0] m_ctrl;
  logic [11:0] zero_a [7] = '{sbm_pkg::ADDR_DATA, sbm_pkg::ADDR_INDEX, sbm_pkg::ADDR_TARGET,
    sbm_pkg::ADDR_INT_STAT, sbm_pkg::ADDR_INT_EN, sbm_pkg::ADDR_INT_CLR, 12'h2dc};
  int num_errors;
  int check_count;
  int exp_q[$];
  realtime t_rise;
  realtime scl_per;
  // pull-up absent during the first reset so bus sensing can be seen to fail
  wire scl = scl_oe_ff ? 1'b0 : pu_en;
  wire sda = (sda_oe_ff || rom_oe) ? 1'b0 : pu_en;
  sbm_serial_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(), .scl_sense(scl), .scl_val_ff(),
    .scl_oe_ff(scl_oe_ff), .sda_sense(sda), .sda_val_ff(), .sda_oe_ff(sda_oe_ff),
    .irq_ff(irq_ff), .subsys_id_ff(subsys_id_ff));
  sbm_rom_model u_rom (.scl(scl), .sda(sda), .sda_oe(rom_oe), .nack_all(nack_all),
    .rd_byte(rd_byte));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge scl) begin
    scl_per = $realtime - t_rise;
    t_rise = $realtime;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_frame(input string nm);
    check_count++;
    if (u_rom.ev_q != exp_q) begin
      num_errors++;
      $display("unexpected %s: expected %p seen %p", nm, exp_q, u_rom.ev_q);
    end
    u_rom.ev_q.delete();
  endtask
  // every call starts one edge late so psel never toggles twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    x = prdata_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, x);
  endtask
  task automatic irq_after(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq_ff});
  endtask
  task automatic wait_clear(input int b);
    do begin
      repeat (50) @(posedge pclk);
      apb(1'b0, sbm_pkg::ADDR_CTRL, 32'h0);
    end while (x[b] !== 1'b0);
  endtask
  task automatic chk_per(input int q);
    int c;
    c = int'(scl_per / 4.0);
    chk("scl period", 32'h1, {31'h0, c >= 4 * q - 4 && c <= 4 * q + 4});
  endtask
  task automatic do_reset(input logic pu);
    pu_en <= pu;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    u_rom.ev_q.delete();
  endtask
  task automatic request(input logic sh, input logic r, input logic nk);
    logic [7:0] d;
    logic [7:0] idx;
    logic [7:0] rb;
    logic [6:0] a;
    rnd = lfsr(rnd);
    {idx, d} = rnd;
    rnd = lfsr(rnd);
    {rb, a} = rnd[14:0];
    rd_byte <= rb;
    apb(1'b1, sbm_pkg::ADDR_DATA, {24'h0, d});
    apb(1'b1, sbm_pkg::ADDR_INDEX, {24'h0, idx});
    apb(1'b1, sbm_pkg::ADDR_TARGET, {24'h0, a, r});
    chk_rd("ctrl busy", sbm_pkg::ADDR_CTRL, m_ctrl | 32'h20);
    wait_clear(sbm_pkg::B_REQ_BUSY);
    exp_q = {256};
    if (nk) exp_q.push_back(int'({a, 1'b0}));
    else if (!sh) begin
      exp_q = {exp_q, int'({a, 1'b0}), int'(idx)};
      if (r) exp_q = {exp_q, 256, int'({a, 1'b1})};
    end else exp_q.push_back(int'({a, r}));
    if (!r && !nk) exp_q.push_back(int'(d));
    exp_q.push_back(257);
    chk_frame("frame");
    chk_per(int'(sbm_pkg::QTR_FAST));
    chk_rd("data", sbm_pkg::ADDR_DATA, {24'h0, (r && !nk) ? rb : d});
  endtask
  initial begin
    repeat (96000) @(posedge pclk);
    num_errors++;
    final_report;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    pu_en = 1'b0;
    nack_all = 1'b1;
    rd_byte = 8'h00;
    num_errors = 0;
    check_count = 0;
    rnd = 16'h52f7;
    t_rise = 0;
    scl_per = 0;
    m_ctrl = 32'h0c;
    do_reset(1'b0);
    repeat (300) @(posedge pclk);
    chk_rd("ctrl no bus", sbm_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, 12'h2dc, 32'hff);
    foreach (zero_a[i]) chk_rd("reset value", zero_a[i], 32'h0);
    apb(1'b1, sbm_pkg::ADDR_CTRL, 32'hff);
    chk_rd("ctrl rw", sbm_pkg::ADDR_CTRL, 32'h8c);
    do_reset(1'b1);
    repeat (280) @(posedge pclk);
    chk_rd("ctrl autoload", sbm_pkg::ADDR_CTRL, 32'h18);
    wait_clear(sbm_pkg::B_AUTO_BUSY);
    exp_q = {256, int'({sbm_pkg::ROM_DEV_ADDR, 1'b0}), 257};
    chk_frame("autoload frame");
    chk_per(int'(sbm_pkg::QTR_NORM));
    chk_rd("ctrl rom err", sbm_pkg::ADDR_CTRL, 32'h09);
    chk_rd("int autoload", sbm_pkg::ADDR_INT_STAT, 32'hc);
    chk("subsys id", 32'h0, {16'h0, subsys_id_ff});
    apb(1'b1, sbm_pkg::ADDR_CTRL, 32'h08);
    chk_rd("rom err kept", sbm_pkg::ADDR_CTRL, 32'h09);
    apb(1'b1, sbm_pkg::ADDR_CTRL, 32'h09);
    chk_rd("rom err clear", sbm_pkg::ADDR_CTRL, 32'h08);
    apb(1'b1, sbm_pkg::ADDR_INT_CLR, 32'hf);
    apb(1'b1, sbm_pkg::ADDR_INT_EN, 32'h3);
    chk_rd("int en", sbm_pkg::ADDR_INT_EN, 32'h3);
    nack_all <= 1'b0;
    apb(1'b1, sbm_pkg::ADDR_CTRL, m_ctrl);
    request(1'b0, 1'b1, 1'b0);
    chk_rd("int stat", sbm_pkg::ADDR_INT_STAT, 32'h1);
    irq_after(sbm_pkg::ADDR_INT_EN, 32'h0, 1'b0);
    irq_after(sbm_pkg::ADDR_INT_EN, 32'h3, 1'b1);
    irq_after(sbm_pkg::ADDR_INT_CLR, 32'hf, 1'b0);
    m_ctrl = 32'h8c;
    apb(1'b1, sbm_pkg::ADDR_CTRL, m_ctrl);
    request(1'b1, 1'b0, 1'b0);
    request(1'b1, 1'b1, 1'b0);
    nack_all <= 1'b1;
    request(1'b1, 1'b0, 1'b1);
    chk_rd("ctrl req err", sbm_pkg::ADDR_CTRL, 32'h8e);
    apb(1'b1, sbm_pkg::ADDR_CTRL, m_ctrl);
    chk_rd("req err kept", sbm_pkg::ADDR_CTRL, 32'h8e);
    apb(1'b1, sbm_pkg::ADDR_CTRL, 32'h8e);
    chk_rd("req err clear", sbm_pkg::ADDR_CTRL, m_ctrl);
    chk_rd("int req err", sbm_pkg::ADDR_INT_STAT, 32'h3);
    final_report;
  end
endmodule

bind sbm_serial_ctrl sbm_serial_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .scl_val_ff(scl_val_ff),
  .scl_oe_ff(scl_oe_ff), .sda_val_ff(sda_val_ff), .sda_oe_ff(sda_oe_ff), .irq_ff(irq_ff));
